// ### logic/pvic_pkg.sv
// Constants and types shared by the prioritised vectored interrupt controller.
`default_nettype none
package pvic_pkg;
  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int NUM_SW = 8;
  localparam int NUM_PERIPH = 140;
  localparam int NUM_SRC = NUM_SW + NUM_PERIPH;
  localparam int NUM_EXT = 16;
  localparam int EXT_GRP = 8;
  localparam int NUM_WAKE = 18;
  localparam int WAKE_GRP = 6;
  localparam int NUM_GRP = NUM_EXT / EXT_GRP + NUM_WAKE / WAKE_GRP;
  localparam int NUM_PLAIN = NUM_PERIPH - NUM_GRP;
  localparam int SRC_PLAIN0 = NUM_SW + NUM_GRP;
  localparam int PRI_W = 4;
  localparam int VEC_W = 9;
  localparam int LIFO_DEPTH = 16;
  localparam int SP_W = 5;
  localparam int ADDR_W = 8;
  localparam int PSR_WORDS = 19;
  localparam int PRI_PER_WORD = 8;

  // ---------------------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CPR = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IACK = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_EOI = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_SSC = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_PSR = 8'h40;
  localparam int CTRL_HWVEC_BIT = 0;
  localparam int SSC_SET_LSB = 0;
  localparam int SSC_CLR_LSB = 8;
  localparam logic RST_HWVEC = 1'b0;
  localparam logic [PRI_W-1:0] RST_CPR = 4'h0;
  localparam logic [PRI_W-1:0] RST_PRI = 4'h0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    PVIC_SEL_NONE, PVIC_SEL_CTRL, PVIC_SEL_CPR, PVIC_SEL_IACK,
    PVIC_SEL_EOI, PVIC_SEL_SSC, PVIC_SEL_PSR
  } pvic_sel_t;

  typedef struct packed {
    logic req;
    logic [VEC_W-1:0] vec;
  } pvic_cpu_t;

  typedef struct packed {
    logic dp_valid;
    logic dp_write;
    logic dp_word;
    logic [ADDR_W-1:0] dp_addr;
    logic hready_out;
    logic hresp;
    logic [31:0] hrdata;
    logic hwvec;
    logic [PRI_W-1:0] cpr;
    logic [NUM_SW-1:0] sw_pend;
    logic [NUM_SRC-1:0][PRI_W-1:0] prio;
    logic [LIFO_DEPTH-1:0][PRI_W-1:0] lifo;
    logic [SP_W-1:0] sp;
    logic [NUM_EXT+NUM_WAKE-1:0] pin_s1;
    logic [NUM_EXT+NUM_WAKE-1:0] pin_s2;
    logic [NUM_SRC-1:0] req_s;
    logic win_valid;
    logic [VEC_W-1:0] win_vec;
    logic [PRI_W-1:0] win_pri;
    pvic_cpu_t irq;
    logic [PRI_W-1:0] vec_pri;
  } pvic_state_t;
endpackage
`default_nettype wire

// ### logic/pvic_top.sv
// Prioritised vectored interrupt controller with an AHB-Lite register slave.
`timescale 1ns/100ps
`default_nettype none
// How it works
// [R1] There are 148 sources: vectors 0 to 7 are software requests, 8 to 147 peripheral lines.
// [R2] Vectors 8 and 9 each merge eight external pins, vectors 10 to 12 six wakeup pins each.
// [R3] Each source owns one vector number equal to its index, so no polling is needed.
// [R4] Each source has a 4-bit software-written priority held in the PSR words.
// [R5] Software may write the current priority to keep tasks sharing a resource from preempting.
// [R6] Eight software requests are set and cleared by writes to the SSC register.
// [R7] The vector goes out on irq_out with irq_ack, or is read from IACK, as CTRL selects.
// [R8] A winning request above the current priority raises the request to the core.
// [R9] An acknowledge pushes the current priority onto a LIFO; an EOI write pops it back.
// [R10] The core request rises within three clocks of an irq_src request, and within five of an external or wakeup pin.
// [R11] Other processors or routines set software requests only through bus writes.
// [R12] The vector is a 9-bit binary source index.
// [R13] A request at or below the current priority stays pending and is not forwarded.
module pvic_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [pvic_pkg::NUM_PLAIN-1:0] irq_src,
  input wire logic [pvic_pkg::NUM_EXT-1:0] ext_pins,
  input wire logic [pvic_pkg::NUM_WAKE-1:0] wake_pins,
  input wire logic irq_ack,
  output var pvic_pkg::pvic_cpu_t irq_out
);

  // ---------------------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------------------
  function automatic pvic_pkg::pvic_sel_t reg_sel(input logic [pvic_pkg::ADDR_W-1:0] a);
    logic [pvic_pkg::ADDR_W-1:0] top;
    top = pvic_pkg::OFF_PSR + pvic_pkg::ADDR_W'(4 * pvic_pkg::PSR_WORDS);
    reg_sel = pvic_pkg::PVIC_SEL_NONE;
    if (a == pvic_pkg::OFF_CTRL) begin
      reg_sel = pvic_pkg::PVIC_SEL_CTRL;
    end else if (a == pvic_pkg::OFF_CPR) begin
      reg_sel = pvic_pkg::PVIC_SEL_CPR;
    end else if (a == pvic_pkg::OFF_IACK) begin
      reg_sel = pvic_pkg::PVIC_SEL_IACK;
    end else if (a == pvic_pkg::OFF_EOI) begin
      reg_sel = pvic_pkg::PVIC_SEL_EOI;
    end else if (a == pvic_pkg::OFF_SSC) begin
      reg_sel = pvic_pkg::PVIC_SEL_SSC;
    end else if (a >= pvic_pkg::OFF_PSR && a < top && a[1:0] == 2'h0) begin
      reg_sel = pvic_pkg::PVIC_SEL_PSR;
    end
  endfunction

  // Merges the synchronised pin groups into their shared vectors.
  function automatic logic [pvic_pkg::NUM_GRP-1:0] grp_or(
    input logic [pvic_pkg::NUM_EXT+pvic_pkg::NUM_WAKE-1:0] p);
    grp_or = '0;
    for (int g = 0; g < pvic_pkg::NUM_EXT / pvic_pkg::EXT_GRP; g++) begin
      grp_or[g] = |p[g*pvic_pkg::EXT_GRP +: pvic_pkg::EXT_GRP];
    end
    for (int g = 0; g < pvic_pkg::NUM_WAKE / pvic_pkg::WAKE_GRP; g++) begin
      grp_or[pvic_pkg::NUM_EXT / pvic_pkg::EXT_GRP + g] =
        |p[pvic_pkg::NUM_EXT + g*pvic_pkg::WAKE_GRP +: pvic_pkg::WAKE_GRP];
    end
  endfunction

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  pvic_pkg::pvic_state_t s_r;
  pvic_pkg::pvic_state_t s_nxt;
  logic ack_take;
  logic pop_take;
  logic cpr_wr;
  logic [pvic_pkg::NUM_SW-1:0] sw_set;
  logic [pvic_pkg::NUM_SW-1:0] sw_clr;
  logic [5:0] psr_idx;
  int pidx;

  always_comb begin
    s_nxt = s_r;
    ack_take = 1'b0;
    pop_take = 1'b0;
    cpr_wr = 1'b0;
    sw_set = '0;
    sw_clr = '0;
    psr_idx = 6'((s_r.dp_addr - pvic_pkg::OFF_PSR) >> 2);
    pidx = 0;

    // Pins come from outside the clock domain, peripheral lines do not.
    s_nxt.pin_s1 = {wake_pins, ext_pins}; // [R2]
    s_nxt.pin_s2 = s_r.pin_s1;
    s_nxt.req_s = {irq_src, grp_or(s_r.pin_s2), s_r.sw_pend}; // [R1] [R2] [R3]

    // Highest priority wins; among equals the lowest vector wins.
    s_nxt.win_valid = 1'b0;
    s_nxt.win_pri = '0;
    s_nxt.win_vec = '0;
    for (int i = 0; i < pvic_pkg::NUM_SRC; i++) begin
      if (s_r.req_s[i] && (!s_nxt.win_valid || s_r.prio[i] > s_nxt.win_pri)) begin // [R4]
        s_nxt.win_valid = 1'b1;
        s_nxt.win_pri = s_r.prio[i];
        s_nxt.win_vec = pvic_pkg::VEC_W'(i); // [R3] [R12]
      end
    end

    if (s_r.hwvec && irq_ack && s_r.irq.req) begin
      ack_take = 1'b1; // [R7]
    end

    // -------------------------------------------------------------------------
    // Bus data phase: every transfer takes one wait state.
    // -------------------------------------------------------------------------
    if (s_r.dp_valid) begin
      s_nxt.dp_valid = 1'b0;
      s_nxt.hready_out = 1'b1;
      s_nxt.hrdata = '0;
      if (s_r.dp_write && s_r.dp_word) begin
        unique case (reg_sel(s_r.dp_addr))
          pvic_pkg::PVIC_SEL_CTRL: s_nxt.hwvec = hwdata[pvic_pkg::CTRL_HWVEC_BIT]; // [R7]
          pvic_pkg::PVIC_SEL_CPR: begin
            s_nxt.cpr = hwdata[pvic_pkg::PRI_W-1:0]; // [R5]
            cpr_wr = 1'b1;
          end
          pvic_pkg::PVIC_SEL_EOI: pop_take = (s_r.sp != '0); // [R9]
          pvic_pkg::PVIC_SEL_SSC: begin
            sw_set = hwdata[pvic_pkg::SSC_SET_LSB +: pvic_pkg::NUM_SW]; // [R6] [R11]
            sw_clr = hwdata[pvic_pkg::SSC_CLR_LSB +: pvic_pkg::NUM_SW];
          end
          pvic_pkg::PVIC_SEL_PSR: begin
            for (int k = 0; k < pvic_pkg::PRI_PER_WORD; k++) begin
              pidx = int'(psr_idx) * pvic_pkg::PRI_PER_WORD + k;
              if (pidx < pvic_pkg::NUM_SRC) begin
                s_nxt.prio[pidx] = hwdata[k*pvic_pkg::PRI_W +: pvic_pkg::PRI_W]; // [R4]
              end
            end
          end
          pvic_pkg::PVIC_SEL_IACK, pvic_pkg::PVIC_SEL_NONE: begin
          end
        endcase
      end else if (!s_r.dp_write) begin
        unique case (reg_sel(s_r.dp_addr))
          pvic_pkg::PVIC_SEL_CTRL: s_nxt.hrdata[pvic_pkg::CTRL_HWVEC_BIT] = s_r.hwvec;
          pvic_pkg::PVIC_SEL_CPR: s_nxt.hrdata[pvic_pkg::PRI_W-1:0] = s_r.cpr;
          pvic_pkg::PVIC_SEL_IACK: begin
            s_nxt.hrdata[pvic_pkg::VEC_W-1:0] = s_r.irq.vec; // [R7] [R12]
            if (!s_r.hwvec && s_r.irq.req) begin
              ack_take = 1'b1;
            end
          end
          pvic_pkg::PVIC_SEL_SSC: s_nxt.hrdata[pvic_pkg::NUM_SW-1:0] = s_r.sw_pend;
          pvic_pkg::PVIC_SEL_PSR: begin
            for (int k = 0; k < pvic_pkg::PRI_PER_WORD; k++) begin
              pidx = int'(psr_idx) * pvic_pkg::PRI_PER_WORD + k;
              if (pidx < pvic_pkg::NUM_SRC) begin
                s_nxt.hrdata[k*pvic_pkg::PRI_W +: pvic_pkg::PRI_W] = s_r.prio[pidx];
              end
            end
          end
          pvic_pkg::PVIC_SEL_EOI, pvic_pkg::PVIC_SEL_NONE: begin
          end
        endcase
      end
    end else if (hsel && hready && htrans[1]) begin
      s_nxt.dp_valid = 1'b1;
      s_nxt.dp_write = hwrite;
      s_nxt.dp_word = (hsize == pvic_pkg::HSIZE_WORD);
      s_nxt.dp_addr = haddr[pvic_pkg::ADDR_W-1:0];
      s_nxt.hready_out = 1'b0;
    end

    // A set in the same write as a clear wins.
    s_nxt.sw_pend = (s_r.sw_pend & ~sw_clr) | sw_set; // [R6]

    // -------------------------------------------------------------------------
    // Priority LIFO: pop first so an EOI and a new entry can share a cycle.
    // -------------------------------------------------------------------------
    if (pop_take) begin
      s_nxt.sp = s_r.sp - 1'b1; // [R9]
      s_nxt.cpr = s_r.lifo[s_r.sp - 1'b1];
    end
    if (ack_take) begin
      // Sixteen levels can nest at most sixteen deep, so the guard never bites in use.
      if (s_nxt.sp < pvic_pkg::SP_W'(pvic_pkg::LIFO_DEPTH)) begin
        s_nxt.lifo[s_nxt.sp[3:0]] = s_nxt.cpr; // [R9]
        s_nxt.sp = s_nxt.sp + 1'b1;
      end
      s_nxt.cpr = s_r.vec_pri;
    end

    // Compared against the next mask so an acknowledged request drops at once.
    s_nxt.irq.req = s_r.win_valid && (s_r.win_pri > s_nxt.cpr); // [R8] [R13] [R10]
    if (s_nxt.irq.req) begin
      s_nxt.irq.vec = s_r.win_vec;
      s_nxt.vec_pri = s_r.win_pri;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.hready_out <= 1'b1;
      s_r.hwvec <= pvic_pkg::RST_HWVEC;
      s_r.cpr <= pvic_pkg::RST_CPR;
      s_r.prio <= {pvic_pkg::NUM_SRC{pvic_pkg::RST_PRI}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout = s_r.hready_out;
  assign hresp = s_r.hresp;
  assign hrdata = s_r.hrdata;
  assign irq_out = s_r.irq;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_fwd_above_mask: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
    (s_r.win_valid && s_r.win_pri > s_nxt.cpr) |=> (irq_out.req && irq_out.vec == $past(s_r.win_vec)))
    else $error("request above mask not forwarded");

  a_hold_below_mask: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
    irq_out.req |-> ($past(s_r.win_valid) && $past(s_r.win_pri) > s_r.cpr))
    else $error("request forwarded at or below mask");

  a_irq_latency: assert property (@(posedge hclk) disable iff (!hresetn) // [R10]
    ($rose(irq_src[0]) && s_r.prio[pvic_pkg::SRC_PLAIN0] == 4'hf && s_r.cpr == 4'h0 && !irq_ack)
    |-> ##[1:3] irq_out.req)
    else $error("core request later than three clocks");

  a_push_on_ack: assert property (@(posedge hclk) disable iff (!hresetn) // [R9]
    (ack_take && !pop_take && s_r.sp < 5'h10) |=>
    (s_r.sp == $past(s_r.sp) + 5'h1 && s_r.cpr == $past(s_r.vec_pri)))
    else $error("acknowledge did not push priority");

  a_pop_restore: assert property (@(posedge hclk) disable iff (!hresetn) // [R9]
    (pop_take && !ack_take) |=>
    (s_r.sp == $past(s_r.sp) - 5'h1 && s_r.cpr == $past(s_r.lifo[s_r.sp[3:0] - 4'h1])))
    else $error("EOI did not pop priority");

  a_sw_set: assert property (@(posedge hclk) disable iff (!hresetn) // [R6]
    (sw_set != '0) |=> ((s_r.sw_pend & $past(sw_set)) == $past(sw_set)))
    else $error("software request not set");

  a_mask_write: assert property (@(posedge hclk) disable iff (!hresetn) // [R5]
    (cpr_wr && !ack_take && !pop_take) |=> (s_r.cpr == $past(hwdata[3:0])))
    else $error("mask write lost");

  a_vec_range: assert property (@(posedge hclk) disable iff (!hresetn) // [R12]
    irq_out.req |-> (irq_out.vec < 9'h094 && s_r.vec_pri > s_r.cpr))
    else $error("vector out of range");

  a_bus_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    (hsel && hready && htrans[1] && hreadyout) |=> !hreadyout ##1 (hreadyout && !hresp))
    else $error("bus wait state wrong");

endmodule
`default_nettype wire

// ### testbench/pvic_core_model.sv
// Behavioural processor core that takes hardware-delivered vectors.
`timescale 1ns/100ps
`default_nettype none
module pvic_core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic enable,
  input wire logic [3:0] delay,
  input wire pvic_pkg::pvic_cpu_t irq_out,
  output logic irq_ack,
  output logic [pvic_pkg::VEC_W-1:0] last_vec
);
  logic [3:0] cnt;
  // A programmable wait lets the bench play both a prompt and a slow core.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ack <= 1'b0;
      cnt <= 4'h0;
      last_vec <= '0;
    end else begin
      irq_ack <= 1'b0;
      cnt <= 4'h0;
      if (enable && irq_out.req && !irq_ack) begin
        cnt <= cnt + 4'h1;
        if (cnt == delay) begin
          irq_ack <= 1'b1;
          last_vec <= irq_out.vec;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/prioritized_vectored_irq_ctrl_tb.sv
// Self-checking testbench for the prioritised vectored interrupt controller.
`timescale 1ns/100ps
`default_nettype none
module prioritized_vectored_irq_ctrl_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [31:0] wd;
  logic [pvic_pkg::NUM_PLAIN-1:0] irq_src = '0;
  logic [pvic_pkg::NUM_EXT-1:0] ext_pins = '0;
  logic [pvic_pkg::NUM_WAKE-1:0] wake_pins = '0;
  logic irq_ack;
  logic core_en = 1'b0;
  logic [3:0] core_delay = 4'h0;
  logic [pvic_pkg::VEC_W-1:0] last_vec;
  pvic_pkg::pvic_cpu_t irq_out;
  int miscompares = 0;
  int comparisons = 0;
  int k;
  int v;
  int p;
  always #5 hclk = ~hclk;
  assign hready = hreadyout;
  pvic_top i_pvic_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_src(irq_src),
    .ext_pins(ext_pins), .wake_pins(wake_pins), .irq_ack(irq_ack), .irq_out(irq_out));
  pvic_core_model i_pvic_core_model (.hclk(hclk), .hresetn(hresetn), .enable(core_en),
    .delay(core_delay), .irq_out(irq_out), .irq_ack(irq_ack), .last_vec(last_vec));
  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      check("hready", hready, 32'h1);
      wrap_up();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wait_req(input logic val);
    int n;
    n = 0;
    while (irq_out.req !== val && n < 40) begin
      @(posedge hclk);
      #1;
      n++;
    end
    check("irq_out.req", irq_out.req, val);
    if (irq_out.req !== val) wrap_up();
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(name, rd, exp);
    check("hresp", hresp, 32'h0);
  endtask
  function automatic logic [7:0] psr_addr(input int w);
    return pvic_pkg::OFF_PSR + 8'(4 * w);
  endfunction
  // Vectors above the last source have no priority storage.
  function automatic logic [31:0] psr_exp(input int w, input logic [31:0] d);
    return (w == 18) ? (d & 32'h0000ffff) : d;
  endfunction
  function automatic int pin_vec(input int j);
    return (j < 16) ? 8 + j / 8 : 10 + (j - 16) / 6;
  endfunction
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    void'($urandom(11));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("ctrl", pvic_pkg::OFF_CTRL, 32'h0);
    rd_chk("cpr", pvic_pkg::OFF_CPR, 32'h0);
    rd_chk("ssc", pvic_pkg::OFF_SSC, 32'h0);
    xfer(1'b1, 8'h30, 32'hffffffff);
    rd_chk("unmapped", 8'h30, 32'h0);
    for (k = 0; k < 19; k++) begin
      wd = $urandom;
      xfer(1'b1, psr_addr(k), wd);
      rd_chk("psr", psr_addr(k), psr_exp(k, wd));
    end
    for (k = 0; k < 8; k++) begin
      v = 13 + $urandom_range(134);
      p = $urandom_range(15, 1);
      xfer(1'b1, psr_addr(v / 8), 32'(p) << (4 * (v % 8)));
      irq_src[v-13] <= 1'b1;
      repeat (2) @(posedge hclk);
      #1;
      check("req early", irq_out.req, 32'h0);
      @(posedge hclk);
      #1;
      check("req", irq_out.req, 32'h1);
      check("vec", irq_out.vec, 32'(v));
      xfer(1'b1, pvic_pkg::OFF_CPR, 32'(p));
      wait_req(1'b0);
      xfer(1'b1, pvic_pkg::OFF_CPR, 32'(p - 1));
      wait_req(1'b1);
      irq_src[v-13] <= 1'b0;
      xfer(1'b1, pvic_pkg::OFF_CPR, 32'h0);
      wait_req(1'b0);
    end
    xfer(1'b1, psr_addr(1), 32'h00f00000);
    irq_src[0] <= 1'b1;
    wait_req(1'b1);
    rd_chk("iack", pvic_pkg::OFF_IACK, 32'd13);
    wait_req(1'b0);
    rd_chk("cpr pushed", pvic_pkg::OFF_CPR, 32'hf);
    irq_src[0] <= 1'b0;
    xfer(1'b1, pvic_pkg::OFF_EOI, 32'h0);
    rd_chk("cpr popped", pvic_pkg::OFF_CPR, 32'h0);
    // Software request i gets priority i+1, so all eight together must yield vector 7.
    xfer(1'b1, psr_addr(0), 32'h87654321);
    for (k = 0; k < 8; k++) begin
      xfer(1'b1, pvic_pkg::OFF_SSC, 32'h1 << k);
      wait_req(1'b1);
      check("sw vec", irq_out.vec, 32'(k));
      rd_chk("ssc pend", pvic_pkg::OFF_SSC, 32'h1 << k);
      xfer(1'b1, pvic_pkg::OFF_SSC, 32'h100 << k);
      wait_req(1'b0);
    end
    xfer(1'b1, pvic_pkg::OFF_SSC, 32'h000000ff);
    wait_req(1'b1);
    check("winner", irq_out.vec, 32'd7);
    xfer(1'b1, pvic_pkg::OFF_SSC, 32'h0000ff00);
    wait_req(1'b0);
    xfer(1'b1, psr_addr(1), 32'h00022222);
    for (k = 0; k < 34; k++) begin
      {wake_pins, ext_pins} <= 34'h1 << k;
      wait_req(1'b1);
      check("pin vec", irq_out.vec, 32'(pin_vec(k)));
      {wake_pins, ext_pins} <= '0;
      wait_req(1'b0);
    end
    xfer(1'b1, pvic_pkg::OFF_CTRL, 32'h1);
    xfer(1'b1, psr_addr(1), 32'h05f00000);
    core_en <= 1'b1;
    core_delay <= 4'($urandom_range(7));
    irq_src[1] <= 1'b1;
    wait_req(1'b1);
    wait_req(1'b0);
    check("hw vec", last_vec, 32'd14);
    rd_chk("cpr lvl1", pvic_pkg::OFF_CPR, 32'h5);
    irq_src[0] <= 1'b1;
    wait_req(1'b1);
    wait_req(1'b0);
    check("hw vec2", last_vec, 32'd13);
    rd_chk("cpr lvl2", pvic_pkg::OFF_CPR, 32'hf);
    irq_src[0] <= 1'b0;
    xfer(1'b1, pvic_pkg::OFF_EOI, 32'h0);
    rd_chk("cpr pop1", pvic_pkg::OFF_CPR, 32'h5);
    irq_src[1] <= 1'b0;
    xfer(1'b1, pvic_pkg::OFF_EOI, 32'h0);
    rd_chk("cpr pop2", pvic_pkg::OFF_CPR, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
